// >>> logic/lbrg_defs.vh
`ifndef LBRG_DEFS_VH
`define LBRG_DEFS_VH
// Bus state encoding supplied by the bus timing logic
`define LBRG_T_IDLE 3'h0
`define LBRG_T_1 3'h1
`define LBRG_T_2 3'h2
`define LBRG_T_3 3'h3
`define LBRG_T_W 3'h4
`define LBRG_T_4 3'h5
// Queue status codes
`define LBRG_QS_NOP 2'h0
`define LBRG_QS_FIRST 2'h1
`define LBRG_QS_EMPTY 2'h2
`define LBRG_QS_NEXT 2'h3
// Late-start window after an idle-bus request, in clocks
`define LBRG_IDLE_WINDOW 2'h3
// Reset values
`define LBRG_RG_OUT_RST 1'b1
`define LBRG_LOCK_RST 1'b1
`endif

// >>> logic/lbrg_rg_sampler.v
`timescale 1ns/1ps
`include "lbrg_defs.vh"
// Samples request/grant lines; a floating line reads high by bus hold
module lbrg_rg_sampler #(
  parameter N = 2
) (
  input wire i_sys_clk,
  input wire i_rst_b,
  input wire [N-1:0] i_line,
  input wire [N-1:0] i_line_oe_b,
  output reg [N-1:0] o_low_pulse
);
  reg [N-1:0] held_reg;
  genvar g;
  generate
    for (g = 0; g < N; g = g + 1) begin : g_ch
      // Bus hold keeps last level; reset level is inactive high
      always @(posedge i_sys_clk) begin
        if (!i_rst_b) begin
          held_reg[g] <= 1'b1;
          o_low_pulse[g] <= 1'b0;
        end else begin
          held_reg[g] <= i_line_oe_b[g] ? i_line[g] : 1'b0;
          o_low_pulse[g] <= ~i_line[g] & i_line_oe_b[g];
        end
      end
    end
  endgenerate
endmodule // lbrg_rg_sampler

// >>> logic/lbrg_qs_stage.v
`timescale 1ns/1ps
`include "lbrg_defs.vh"
// Delays the queue operation code by one clock onto the status pins
module lbrg_qs_stage (
  input wire i_sys_clk,
  input wire i_rst_b,
  input wire [1:0] i_queue_op,
  output reg o_queue_state_msb,
  output reg o_queue_state_lsb
);
  // Always driven, never floated, even during grant
  always @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      o_queue_state_msb <= 1'b0;
      o_queue_state_lsb <= 1'b0;
    end else begin
      o_queue_state_msb <= i_queue_op[1];
      o_queue_state_lsb <= i_queue_op[0];
    end
  end
endmodule // lbrg_qs_stage

// >>> logic/lbrg_top.v
`timescale 1ns/1ps
`include "lbrg_defs.vh"
module lbrg_top (
  input wire i_sys_clk,
  input wire i_rst_b,
  input wire i_bus_request_grant_high_prio,
  input wire i_bus_request_grant_low_prio,
  input wire [2:0] i_bus_state,
  input wire i_mem_cycle,
  input wire i_odd_low_byte,
  input wire i_interrupt_ack_cycle,
  input wire i_cycle_pending,
  input wire i_lock_prefix,
  input wire i_instr_done,
  input wire i_bus_mode_select,
  input wire [1:0] i_queue_op,
  output reg o_bus_request_grant_high_prio,
  output reg o_bus_request_grant_high_prio_oe_b,
  output reg o_bus_request_grant_low_prio,
  output reg o_bus_request_grant_low_prio_oe_b,
  output reg o_lock_b,
  output reg o_lock_oe_b,
  output reg o_bus_float,
  output reg o_biu_hold,
  output reg o_resume_t1,
  output wire o_queue_state_msb,
  output wire o_queue_state_lsb
);
  localparam ST_IDLE = 3'h0;
  localparam ST_PEND = 3'h1;
  localparam ST_GRANT = 3'h2;
  localparam ST_HELD = 3'h3;
  localparam ST_GAP = 3'h4;

  wire [1:0] req_pulse;
  reg [2:0] state_reg;
  reg [2:0] state_next;
  reg chan_reg;
  reg chan_next;
  reg timely_reg;
  reg timely_next;
  reg [1:0] win_reg;
  reg [1:0] win_next;
  reg ack_first_reg;
  reg prefix_lock_reg;
  reg ack_lock_reg;
  reg seen_t2_reg;
  reg ack_lock_now;
  reg in_t4_t1;
  reg may_release;
  wire req_any;
  wire req_chan;
  wire in_grant;
  wire chan_pulse;

  // Each line reads back its own drive; only sampled when not driving
  lbrg_rg_sampler #(.N(2)) u_sampler (
    .i_sys_clk(i_sys_clk),
    .i_rst_b(i_rst_b),
    .i_line({i_bus_request_grant_low_prio, i_bus_request_grant_high_prio}),
    .i_line_oe_b({o_bus_request_grant_low_prio_oe_b, o_bus_request_grant_high_prio_oe_b}),
    .o_low_pulse(req_pulse)
  );

  lbrg_qs_stage u_qs (
    .i_sys_clk(i_sys_clk),
    .i_rst_b(i_rst_b),
    .i_queue_op(i_queue_op),
    .o_queue_state_msb(o_queue_state_msb),
    .o_queue_state_lsb(o_queue_state_lsb)
  );

  assign req_any = |req_pulse;
  assign req_chan = req_pulse[0] ? 1'b0 : 1'b1;
  assign chan_pulse = chan_reg ? req_pulse[1] : req_pulse[0];
  assign in_grant = (state_reg == ST_HELD);

  // Release qualifiers evaluated at the grant point
  always @* begin
    in_t4_t1 = (i_bus_state == `LBRG_T_4) || (i_bus_state == `LBRG_T_1) ||
               (i_bus_state == `LBRG_T_IDLE);
    may_release = timely_reg
                  & ~i_odd_low_byte
                  & ~ack_first_reg
                  & ~prefix_lock_reg;
  end

  // Request/grant sequencer: request, grant, release, idle gap
  always @* begin
    state_next = state_reg;
    chan_next = chan_reg;
    timely_next = timely_reg;
    win_next = win_reg;
    case (state_reg)
      ST_IDLE: begin
        if (req_any) begin
          state_next = ST_PEND;
          chan_next = req_chan;
          // Idle bus, or T1, T2 or T4 of any cycle, counts as on time
          timely_next = (i_bus_state == `LBRG_T_IDLE) || (i_bus_state == `LBRG_T_1) ||
                        (i_bus_state == `LBRG_T_2) || (i_bus_state == `LBRG_T_4);
          win_next = (i_bus_state == `LBRG_T_IDLE) ? `LBRG_IDLE_WINDOW : 2'h0;
        end
      end
      ST_PEND: begin
        // A cycle starting inside the idle window keeps the request timely
        if (win_reg != 2'h0) begin
          win_next = win_reg - 2'h1;
        end
        if (in_t4_t1 && may_release) begin
          state_next = ST_GRANT;
        end else if (i_bus_state == `LBRG_T_3 && win_reg == 2'h0) begin
          timely_next = seen_t2_reg ? timely_reg : 1'b0;
        end
      end
      ST_GRANT: begin
        state_next = ST_HELD;
      end
      ST_HELD: begin
        if (chan_pulse) begin
          state_next = ST_GAP;
        end
      end
      ST_GAP: begin
        state_next = ST_IDLE;
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  // Sequencer registers and a T2 marker for the arrival check
  always @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      state_reg <= ST_IDLE;
      chan_reg <= 1'b0;
      timely_reg <= 1'b0;
      win_reg <= 2'h0;
      seen_t2_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      chan_reg <= chan_next;
      timely_reg <= timely_next;
      win_reg <= win_next;
      // Request seen before T3 of this cycle
      seen_t2_reg <= (state_reg == ST_IDLE) ? 1'b1 :
                     (i_bus_state == `LBRG_T_4) ? 1'b0 : seen_t2_reg;
    end
  end

  // Grant pulse drive; lines are released otherwise so bus hold keeps them high
  always @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      o_bus_request_grant_high_prio <= `LBRG_RG_OUT_RST;
      o_bus_request_grant_low_prio <= `LBRG_RG_OUT_RST;
      o_bus_request_grant_high_prio_oe_b <= 1'b1;
      o_bus_request_grant_low_prio_oe_b <= 1'b1;
    end else begin
      o_bus_request_grant_high_prio <= 1'b1;
      o_bus_request_grant_low_prio <= 1'b1;
      o_bus_request_grant_high_prio_oe_b <= 1'b1;
      o_bus_request_grant_low_prio_oe_b <= 1'b1;
      if (state_next == ST_GRANT) begin
        // One clock low pulse back on the winning channel
        if (chan_next) begin
          o_bus_request_grant_low_prio <= 1'b0;
          o_bus_request_grant_low_prio_oe_b <= 1'b0;
        end else begin
          o_bus_request_grant_high_prio <= 1'b0;
          o_bus_request_grant_high_prio_oe_b <= 1'b0;
        end
      end
    end
  end

  // Bus float and BIU hold cover the grant pulse and the held state, not the pending or gap states
  always @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      o_bus_float <= 1'b0;
      o_biu_hold <= 1'b0;
      o_resume_t1 <= 1'b0;
    end else begin
      o_bus_float <= (state_next == ST_GRANT) || (state_next == ST_HELD);
      o_biu_hold <= (state_next == ST_HELD) || (state_next == ST_GRANT);
      // Reclaim: T4 if a cycle is waiting, else T1
      o_resume_t1 <= (state_reg == ST_HELD) && chan_pulse && !i_cycle_pending;
    end
  end

  // Lock sources: prefix until next instruction ends, and acknowledge pair
  always @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      prefix_lock_reg <= 1'b0;
      ack_lock_reg <= 1'b0;
      ack_first_reg <= 1'b0;
    end else begin
      if (i_lock_prefix) begin
        prefix_lock_reg <= 1'b1;
      end else if (i_instr_done) begin
        prefix_lock_reg <= 1'b0;
      end
      if (i_interrupt_ack_cycle && i_bus_state == `LBRG_T_2 && !i_bus_mode_select) begin
        ack_lock_reg <= ~ack_first_reg;
        ack_first_reg <= ~ack_first_reg;
      end
    end
  end

  // Acknowledge lock as it becomes in this T2, so the pin follows in the same clock
  always @* begin
    if (i_interrupt_ack_cycle && i_bus_state == `LBRG_T_2 && !i_bus_mode_select) begin
      ack_lock_now = ~ack_first_reg;
    end else begin
      ack_lock_now = ack_lock_reg;
    end
  end

  // Lock pin; floated high while the bus is granted away
  always @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      o_lock_b <= `LBRG_LOCK_RST;
      o_lock_oe_b <= 1'b0;
    end else if (in_grant || state_next == ST_HELD) begin
      o_lock_b <= 1'b1;
      o_lock_oe_b <= 1'b1;
    end else begin
      o_lock_b <= ~(prefix_lock_reg | i_lock_prefix | ack_lock_now);
      o_lock_oe_b <= 1'b0;
    end
  end
endmodule // lbrg_top

// >>> dv/lbrg_props.sv
`timescale 1ns/1ps
// Port relations that must hold for any legal stimulus
module lbrg_props (
  input wire i_sys_clk,
  input wire i_rst_b,
  input wire i_bus_request_grant_high_prio,
  input wire i_lock_prefix,
  input wire [1:0] i_queue_op,
  input wire o_bus_request_grant_high_prio_oe_b,
  input wire o_bus_request_grant_low_prio_oe_b,
  input wire o_lock_b,
  input wire o_lock_oe_b,
  input wire o_bus_float,
  input wire o_biu_hold,
  input wire o_queue_state_msb,
  input wire o_queue_state_lsb
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_b);
  grant_pulse_a: assert property ($fell(o_bus_request_grant_high_prio_oe_b) |=>
    o_bus_request_grant_high_prio_oe_b) else $error("grant pulse too long");
  grant_excl_a: assert property (o_bus_request_grant_high_prio_oe_b ||
    o_bus_request_grant_low_prio_oe_b) else $error("two grants at once");
  grant_float_a: assert property (!o_bus_request_grant_high_prio_oe_b |->
    o_bus_float && o_biu_hold) else $error("grant without float");
  bus_back_a: assert property (o_bus_float && !i_bus_request_grant_high_prio &&
    o_bus_request_grant_high_prio_oe_b |=> ##1 !o_bus_float) else $error("bus kept");
  lock_float_a: assert property (o_biu_hold && $past(o_biu_hold) |->
    o_lock_oe_b && o_lock_b) else $error("lock not floated");
  lock_set_a: assert property (i_lock_prefix |=> !o_lock_b) else $error("no lock");
  lock_nogrant_a: assert property (!o_lock_b |->
    o_bus_request_grant_high_prio_oe_b) else $error("grant while locked");
  queue_lag_a: assert property ($past(i_rst_b) |->
    {o_queue_state_msb, o_queue_state_lsb} == $past(i_queue_op)) else $error("queue lag");
endmodule // lbrg_props

// >>> dv/lbrg_master_model.sv
`timescale 1ns/1ps
// Far-side master: request, wait for grant, hold three clocks, release
module lbrg_master_model (
  input wire i_sys_clk,
  input wire i_line,
  input wire i_go,
  output reg o_pull_low = 1'b0,
  output reg o_busy = 1'b0
);
  integer n;
  // Gives up without a release if no grant comes, so a refused request ends clean
  always @(posedge i_sys_clk) begin
    if (i_go && !o_busy) begin
      o_busy <= 1'b1;
      o_pull_low <= 1'b1;
      @(posedge i_sys_clk) o_pull_low <= 1'b0;
      n = 0;
      do begin
        @(posedge i_sys_clk);
        n = n + 1;
      end while (i_line && n < 40);
      if (n < 40) begin
        repeat (3) @(posedge i_sys_clk);
        o_pull_low <= 1'b1;
        @(posedge i_sys_clk) o_pull_low <= 1'b0;
      end
      repeat (2) @(posedge i_sys_clk);
      o_busy <= 1'b0;
    end
  end
endmodule // lbrg_master_model

// >>> dv/lbrg_tb_top.sv
`timescale 1ns/1ps
`include "lbrg_defs.vh"
`define CHK(s, e, g) begin compares++; if ((g) !== (e)) begin n_errors++; \
  $display("CHECK FAILED %s exp %h got %h", s, e, g); end end
`define WT(x) begin c = 0; while (!(x) && c < 60) begin tick(1); c++; end end
module lbrg_tb_top;
  reg clk = 1'b0, rst_b = 1'b0, odd = 1'b0, ack = 1'b0, pre = 1'b0, done = 1'b0;
  reg hgo = 1'b0, lgo = 1'b0;
  reg [2:0] st = `LBRG_T_IDLE;
  reg [1:0] qop = 2'h0;
  wire hv, hoe, lv, loe, lk, lkoe, flt, hold, rt1, qm, ql, hpl, lpl, hb, lb;
  integer n_errors = 0, compares = 0;
  // Undriven line stays high through the bus hold
  wire hl = !hoe ? hv : !hpl;
  wire ll = !loe ? lv : !lpl;
  always #25 clk = !clk;
  lbrg_top dut (.i_sys_clk(clk), .i_rst_b(rst_b), .i_bus_request_grant_high_prio(hl),
    .i_bus_request_grant_low_prio(ll), .i_bus_state(st), .i_mem_cycle(odd),
    .i_odd_low_byte(odd), .i_interrupt_ack_cycle(ack), .i_cycle_pending(1'b0),
    .i_lock_prefix(pre), .i_instr_done(done), .i_bus_mode_select(1'b0), .i_queue_op(qop),
    .o_bus_request_grant_high_prio(hv), .o_bus_request_grant_high_prio_oe_b(hoe),
    .o_bus_request_grant_low_prio(lv), .o_bus_request_grant_low_prio_oe_b(loe),
    .o_lock_b(lk), .o_lock_oe_b(lkoe), .o_bus_float(flt), .o_biu_hold(hold),
    .o_resume_t1(rt1), .o_queue_state_msb(qm), .o_queue_state_lsb(ql));
  lbrg_master_model u_hm (.i_sys_clk(clk), .i_line(hl), .i_go(hgo), .o_pull_low(hpl), .o_busy(hb));
  lbrg_master_model u_lm (.i_sys_clk(clk), .i_line(ll), .i_go(lgo), .o_pull_low(lpl), .o_busy(lb));
  task automatic tick(input integer k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task automatic req(input reg h, input reg l);
    @(posedge clk);
    hgo <= h;
    lgo <= l;
    @(posedge clk);
    hgo <= 1'b0;
    lgo <= 1'b0;
  endtask
  task automatic t_qs;
    integer i;
    for (i = 0; i < 4; i++) begin
      @(posedge clk);
      qop <= i[1:0];
      tick(1);
      `CHK("queue state", i[1:0], {qm, ql})
    end
    $display("%m done");
  endtask
  task automatic t_idle;
    integer c;
    req(1'b1, 1'b0);
    `WT(!hoe)
    `CHK("grant", 1'b0, hv)
    `WT(!flt)
    `CHK("resume t1", 1'b1, rt1)
    `WT(!hb)
    $display("%m done");
  endtask
  // Simultaneous requests: the low channel is dropped, then served alone
  task automatic t_tie;
    integer c;
    req(1'b1, 1'b1);
    `WT(!hoe)
    `CHK("low waits", 1'b1, loe)
    `WT(!hb && !lb)
    req(1'b0, 1'b1);
    `WT(!loe)
    `CHK("low grant", 1'b0, lv)
    `WT(!lb)
    $display("%m done");
  endtask
  task automatic t_lock;
    integer c;
    @(posedge clk);
    pre <= 1'b1;
    @(posedge clk);
    pre <= 1'b0;
    req(1'b1, 1'b0);
    tick(6);
    `CHK("withheld", 3'h4, {hoe, lk, flt})
    @(posedge clk);
    done <= 1'b1;
    @(posedge clk);
    done <= 1'b0;
    `WT(!hoe)
    `CHK("late grant", 1'b0, hv)
    `WT(!hb)
    $display("%m done");
  endtask
  task automatic t_odd;
    integer c;
    @(posedge clk);
    st <= `LBRG_T_4;
    odd <= 1'b1;
    req(1'b1, 1'b0);
    tick(6);
    `CHK("odd withheld", 2'h2, {hoe, flt})
    @(posedge clk);
    odd <= 1'b0;
    `WT(!hoe)
    `CHK("odd grant", 1'b0, hv)
    `WT(!hb)
    @(posedge clk);
    st <= `LBRG_T_IDLE;
    $display("%m done");
  endtask
  task automatic t_ack;
    @(posedge clk);
    st <= `LBRG_T_2;
    ack <= 1'b1;
    @(posedge clk);
    st <= `LBRG_T_3;
    #1;
    `CHK("ack lock", 1'b0, lk)
    @(posedge clk);
    st <= `LBRG_T_2;
    @(posedge clk);
    st <= `LBRG_T_IDLE;
    ack <= 1'b0;
    #1;
    `CHK("ack unlock", 1'b1, lk)
    $display("%m done");
  endtask
  task automatic final_report;
    $display("compares %0d n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    tick(1);
    `CHK("reset", 7'h70, {hoe, loe, lk, lkoe, flt, qm, ql})
    t_qs;
    t_idle;
    t_tie;
    t_lock;
    t_odd;
    t_ack;
    final_report;
  end
  // Hang guard
  initial begin
    repeat (3000) @(posedge clk);
    n_errors++;
    final_report;
  end
endmodule // lbrg_tb_top
bind lbrg_top lbrg_props u_props (.i_sys_clk, .i_rst_b, .i_bus_request_grant_high_prio,
  .i_lock_prefix, .i_queue_op, .o_bus_request_grant_high_prio_oe_b,
  .o_bus_request_grant_low_prio_oe_b, .o_lock_b, .o_lock_oe_b, .o_bus_float, .o_biu_hold,
  .o_queue_state_msb, .o_queue_state_lsb);
